// [dv/brms_bus_partner.sv]
module brms_bus_partner (
  // From the bench; pullup_en_i comes from the design
  input wire rst_req_i,
  input wire [1:0] mode_i,
  input wire [1:0] kind_i,
  input wire good_req_i,
  input wire pullup_en_i,
  // Bus side
  output logic up_clk_o,
  output logic dn_clk_o,
  output logic rst_n_o,
  output logic [2:0] pat_o,
  output logic good_o,
  output logic sense_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] hold_r = 2'h0;
  logic [3:0] good_cnt_r = 4'h0;
  initial begin
    up_clk_o = 1'b0;
    dn_clk_o = 1'b0;
    rst_n_o = 1'b0;
  end
  always #62.5 up_clk_o = ~up_clk_o;
  initial begin
    #23;
    forever #62.5 dn_clk_o = ~dn_clk_o;
  end
  always @(posedge up_clk_o) begin
    rst_n_o <= !rst_req_i;
    hold_r <= !rst_n_o ? 2'h0 : (hold_r == 2'h3) ? hold_r : hold_r + 2'h1;
  end
  // Pattern held two clocks past reset, then the pull-ups win
  assign pat_o = (hold_r < 2'h2) ? 3'h7 - {1'b0, mode_i} : 3'h7;
  always @(posedge dn_clk_o) begin
    good_cnt_r <= !good_req_i ? 4'h0 : (good_cnt_r == 4'h8) ? good_cnt_r : good_cnt_r + 4'h1;
  end
  assign good_o = good_cnt_r == 4'h8;
  // Clients: 0 ties the net low, 1 pulls it weakly low, 2 leaves it high
  assign sense_o = (kind_i == 2'h2) || (kind_i == 2'h1 && pullup_en_i);
endmodule // brms_bus_partner

// [dv/brms_reset_sequencer_monitor.sv]
module brms_reset_sequencer_monitor (
  // Clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // Upstream side
  input wire upstream_bus_reset_n_i,
  input wire upstream_pll_reset_n_o,
  input wire [1:0] upstream_pll_range_o,
  input wire upstream_logic_reset_n_o,
  // Downstream side
  input wire downstream_clk_i,
  input wire downstream_impedance_invert_i,
  input wire downstream_bus_reset_n_o,
  input wire downstream_drive_p2p_o,
  input wire downstream_pll_reset_n_o,
  input wire [1:0] downstream_pll_range_o,
  input wire downstream_logic_reset_n_o,
  input wire [31:0] downstream_ad_o,
  input wire downstream_ad_oe_o,
  input wire [3:0] downstream_cmd_byte_en_o,
  input wire downstream_cmd_byte_en_oe_o,
  input wire downstream_parity_o,
  input wire downstream_wide_request_n_o,
  input wire downstream_wide_request_n_oe_o,
  input wire downstream_pattern_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] dclk_r;
  logic [4:0] bcast_r;
  // Counts downstream edges of an unbroken broadcast with the wide request low
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dclk_r <= 2'b00;
      bcast_r <= 5'h00;
    end else begin
      dclk_r <= {dclk_r[0], downstream_clk_i};
      if (!(downstream_pattern_oe_o && downstream_wide_request_n_oe_o
            && !downstream_wide_request_n_o))
        bcast_r <= 5'h00;
      else if (dclk_r == 2'b01 && bcast_r != 5'h1f)
        bcast_r <= bcast_r + 5'h01;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_DS_RST_AT_ONCE: assert property (
    !upstream_bus_reset_n_i |-> !downstream_bus_reset_n_o)
    else $error("downstream reset not asserted with upstream reset");
  AST_PARK_HELD: assert property (
    !downstream_bus_reset_n_o [*6] |-> downstream_ad_oe_o && downstream_cmd_byte_en_oe_o)
    else $error("downstream bus not parked during reset");
  AST_PARK_ZERO: assert property (
    downstream_ad_oe_o |-> downstream_ad_o == 32'h0000_0000
      && downstream_cmd_byte_en_o == 4'h0 && !downstream_parity_o)
    else $error("parked lines not zero");
  AST_PARK_FLOAT: assert property (
    $rose(downstream_bus_reset_n_o) |=> !downstream_ad_oe_o && !downstream_cmd_byte_en_oe_o)
    else $error("parked lines not floated after reset");
  AST_WIDE_TEN: assert property (
    $rose(downstream_bus_reset_n_o) |-> bcast_r >= 5'h0a)
    else $error("broadcast shorter than ten downstream cycles");
  AST_DS_IMP: assert property (
    $rose(downstream_bus_reset_n_o) |-> ##2 downstream_drive_p2p_o ==
      ((downstream_pll_range_o == 2'h3) ^ downstream_impedance_invert_i))
    else $error("downstream impedance wrong");
  AST_UP_PLL: assert property (
    upstream_logic_reset_n_o |-> upstream_pll_reset_n_o == (upstream_pll_range_o != 2'h0))
    else $error("upstream pll reset wrong for mode");
  AST_DS_PLL: assert property (
    downstream_logic_reset_n_o |-> downstream_pll_reset_n_o == (downstream_pll_range_o != 2'h0))
    else $error("downstream pll reset wrong for mode");
  AST_UP_HOLD: assert property (
    !upstream_bus_reset_n_i [*6] |-> !upstream_logic_reset_n_o)
    else $error("upstream logic out of reset during bus reset");
  AST_DS_LOGIC_AFTER: assert property (
    $rose(downstream_logic_reset_n_o) |-> downstream_bus_reset_n_o)
    else $error("downstream logic released before bus reset");
endmodule // brms_reset_sequencer_monitor

// [dv/brms_reset_sequencer_tb_top.sv]
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
`define WAITF(c) begin wc = 0; while (!(c) && wc < 20000) begin @(negedge clk_sys_i); wc++; \
  end if (!(c)) begin n_mismatch++; $display("wrong value wait exp 1 got 0"); close_out(); end end
module brms_reset_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int P66 = 20, PHI = 30, X66 = 20, XHI = 30, S66 = 25, SHI = 35;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0000_0000, rq;
  logic upstream_impedance_invert_i = 1'b0, downstream_impedance_invert_i = 1'b0;
  logic downstream_freq_range_select_i = 1'b0, rst_req = 1'b1, good_req = 1'b1, ep;
  logic [1:0] mode = 2'h0, kind = 2'h0;
  int n_mismatch = 0, total_checks = 0, ucnt = 0, dcnt = 0, wc, mi, si, ki, n, t0, d0;
  wire [31:0] avs_readdata_o;
  wire [2:0] pat, downstream_pattern_o;
  wire [1:0] upstream_pll_range_o, downstream_pll_range_o;
  wire avs_waitrequest_o, upstream_bus_reset_n_i, upstream_clk_i, downstream_clk_i;
  wire downstream_clk_good_i, downstream_capability_sense_i, capability_strong_pullup_en_o;
  wire upstream_drive_p2p_o, upstream_pll_reset_n_o, upstream_logic_reset_n_o;
  wire downstream_bus_reset_n_o, downstream_drive_p2p_o, downstream_logic_reset_n_o;
  wire downstream_ad_oe_o, downstream_pattern_oe_o;
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge upstream_clk_i) ucnt++;
  realtime dt_last = 0.0;
  always @(posedge downstream_clk_i) begin
    dcnt++;
    dt_last = $realtime;
  end
  brms_bus_partner i_partner (.rst_req_i(rst_req), .mode_i(mode), .kind_i(kind),
    .good_req_i(good_req), .pullup_en_i(capability_strong_pullup_en_o),
    .up_clk_o(upstream_clk_i), .dn_clk_o(downstream_clk_i), .rst_n_o(upstream_bus_reset_n_i),
    .pat_o(pat), .good_o(downstream_clk_good_i), .sense_o(downstream_capability_sense_i));
  brms_reset_sequencer #(.P_LOCK_66_CYC(P66), .P_LOCK_HI_CYC(PHI), .XCAP_66_CYC(X66),
    .XCAP_HI_CYC(XHI), .S_LOCK_66_CYC(S66), .S_LOCK_HI_CYC(SHI), .CAP_WAIT_CYC(50)) i_dut (
    .clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .upstream_bus_reset_n_i,
    .upstream_clk_i, .upstream_device_select_n_i(pat[2]), .upstream_stop_n_i(pat[1]),
    .upstream_target_ready_n_i(pat[0]), .upstream_impedance_invert_i, .upstream_drive_p2p_o,
    .upstream_pll_reset_n_o, .upstream_pll_range_o, .upstream_logic_reset_n_o,
    .downstream_clk_i, .downstream_clk_good_i, .downstream_capability_sense_i,
    .downstream_freq_range_select_i, .downstream_impedance_invert_i, .downstream_bus_reset_n_o,
    .capability_strong_pullup_en_o, .downstream_drive_p2p_o, .downstream_pll_reset_n_o(),
    .downstream_pll_range_o, .downstream_logic_reset_n_o, .downstream_ad_o(),
    .downstream_ad_oe_o, .downstream_cmd_byte_en_o(), .downstream_cmd_byte_en_oe_o(),
    .downstream_parity_o(), .downstream_parity_oe_o(), .downstream_wide_request_n_o(),
    .downstream_wide_request_n_oe_o(), .downstream_pattern_o, .downstream_pattern_oe_o);
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    i = 0;
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (avs_waitrequest_o !== 1'b0 && i < 50);
    rq = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    `CHK("bus_answer", 1'b1, avs_waitrequest_o === 1'b0)
    if (avs_waitrequest_o !== 1'b0) close_out();
  endtask
  // Follows one downstream release from the clearing of its last source
  task automatic dn_seq(input int em, input logic s);
    t0 = ucnt;
    `WAITF(downstream_pattern_oe_o === 1'b1)
    `CHK("xcap", 1'b1, ucnt - t0 >= XHI)
    `CHK("dn_pat", 3'h7 - em[2:0], downstream_pattern_o)
    // An edge still in the synchroniser is yet to be counted by the design
    d0 = dcnt - int'(($realtime - dt_last) < 28.0);
    `WAITF(downstream_bus_reset_n_o === 1'b1)
    `CHK("srst_dly", 1'b1, dcnt - d0 >= 11)
    `CHK("dn_range", em[1:0], downstream_pll_range_o)
    `WAITF(downstream_logic_reset_n_o === 1'b1)
    n = (em == 0) ? 16 : (em == 1) ? S66 : SHI;
    `CHK("dn_lock", 1'b1, dcnt - d0 >= n)
    `CHK("dn_p2p", (em == 3) ^ s, downstream_drive_p2p_o)
    av(1'b0, 4'h4, 32'h0000_0000);
    `CHK("st_dn", em[1:0], rq[3:2])
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    `CHK("ds_rst", 1'b0, downstream_bus_reset_n_o)
    `CHK("park_oe", 1'b1, downstream_ad_oe_o)
    av(1'b0, 4'h0, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0000, rq)
    $display("test reset state done");
    for (mi = 0; mi < 4; mi++) begin
      for (si = 0; si < 2; si++) begin
        av(1'b1, 4'h0, 32'h0000_0040);
        rst_req <= 1'b1;
        mode <= mi[1:0];
        upstream_impedance_invert_i <= si[0];
        repeat (40) @(posedge clk_sys_i);
        rst_req <= 1'b0;
        `WAITF(upstream_bus_reset_n_i === 1'b1)
        t0 = ucnt;
        `WAITF(upstream_logic_reset_n_o === 1'b1)
        n = (mi == 0) ? 7 : (mi == 1) ? P66 : PHI;
        `CHK("up_lock", 1'b1, (ucnt - t0 >= n - 1) && (ucnt - t0 <= n + 1))
        `CHK("up_range", mi[1:0], upstream_pll_range_o)
        `CHK("up_pll", mi != 0, upstream_pll_reset_n_o)
        ep = (mi == 3) ^ si[0];
        `CHK("up_p2p", ep, upstream_drive_p2p_o)
        @(posedge clk_sys_i);
        upstream_impedance_invert_i <= !si[0];
        av(1'b0, 4'h0, 32'h0000_0000);
        `CHK("ctrl_clr", 32'h0000_0000, rq)
        av(1'b0, 4'h4, 32'h0000_0000);
        `CHK("st_up", mi[1:0], rq[1:0])
        `CHK("up_p2p_kept", ep, upstream_drive_p2p_o)
      end
    end
    $display("test upstream modes done");
    for (ki = 0; ki < 4; ki++) begin
      kind <= (ki < 2) ? ki[1:0] : 2'h2;
      downstream_freq_range_select_i <= ki == 3;
      downstream_impedance_invert_i <= ki[0];
      av(1'b1, 4'h0, 32'h0000_0040);
      @(negedge clk_sys_i);
      `CHK("ds_set", 1'b0, downstream_bus_reset_n_o)
      repeat (20) @(posedge clk_sys_i); // bit held, time scaled like the lock counts
      av(1'b1, 4'h0, 32'h0000_0000);
      dn_seq((ki < 2) ? ki : 5 - ki, ki[0]);
    end
    $display("test downstream modes done");
    good_req <= 1'b0;
    `WAITF(downstream_clk_good_i === 1'b0)
    av(1'b1, 4'h0, 32'h0000_0040);
    av(1'b1, 4'h0, 32'h0000_0000);
    repeat (1500) @(posedge clk_sys_i);
    `CHK("no_good_rst", 1'b0, downstream_bus_reset_n_o)
    `CHK("no_good_pat", 1'b0, downstream_pattern_oe_o)
    good_req <= 1'b1;
    `WAITF(downstream_pattern_oe_o === 1'b1)
    av(1'b1, 4'h0, 32'h0000_0040);
    @(negedge clk_sys_i);
    `CHK("abort_rst", 1'b0, downstream_bus_reset_n_o)
    repeat (10) @(posedge clk_sys_i);
    `CHK("abort_pat", 1'b0, downstream_pattern_oe_o)
    av(1'b1, 4'h0, 32'h0000_0000);
    dn_seq(2, 1'b1);
    $display("test clock good and abort done");
    av(1'b0, 4'h8, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rq)
    av(1'b1, 4'h8, 32'h0000_0040);
    avs_byteenable_i <= 4'he;
    av(1'b1, 4'h0, 32'h0000_0040);
    avs_byteenable_i <= 4'hf;
    @(negedge clk_sys_i);
    `CHK("refused_wr", 1'b1, downstream_bus_reset_n_o)
    $display("test refused access done");
    close_out();
  end
endmodule // brms_reset_sequencer_tb_top
bind brms_reset_sequencer brms_reset_sequencer_monitor i_mon (.clk_sys_i, .nrst_i,
  .upstream_bus_reset_n_i, .upstream_pll_reset_n_o, .upstream_pll_range_o,
  .upstream_logic_reset_n_o, .downstream_clk_i, .downstream_impedance_invert_i,
  .downstream_bus_reset_n_o, .downstream_drive_p2p_o, .downstream_pll_reset_n_o,
  .downstream_pll_range_o, .downstream_logic_reset_n_o, .downstream_ad_o, .downstream_ad_oe_o,
  .downstream_cmd_byte_en_o, .downstream_cmd_byte_en_oe_o, .downstream_parity_o,
  .downstream_wide_request_n_o, .downstream_wide_request_n_oe_o, .downstream_pattern_oe_o);

// [hw/brms_map.vh]
`ifndef BRMS_MAP_VH
`define BRMS_MAP_VH

// Register byte offsets on the Avalon-MM slave
`define BRMS_REG_CTRL 4'h0
`define BRMS_REG_STATUS 4'h4

// Control register fields
`define BRMS_CTRL_SBR_BIT 6
`define BRMS_CTRL_RESET 32'h0000_0000
`define BRMS_SBR_RESET 1'b0
`define BRMS_RDATA_ZERO 32'h0000_0000

// Status register fields
`define BRMS_ST_PMODE_LO 0
`define BRMS_ST_SMODE_LO 2
`define BRMS_ST_PIMP_BIT 4
`define BRMS_ST_SIMP_BIT 5
`define BRMS_ST_PLOGIC_BIT 6
`define BRMS_ST_SLOGIC_BIT 7
`define BRMS_ST_SBUS_BIT 8
`define BRMS_ST_CLKGOOD_BIT 9

// Bus mode codes
`define BRMS_MODE_PCI 2'h0
`define BRMS_MODE_X66 2'h1
`define BRMS_MODE_X100 2'h2
`define BRMS_MODE_X133 2'h3

// Initialization pattern {device_select_n, stop_n, target_ready_n}
`define BRMS_PAT_PCI 3'h7
`define BRMS_PAT_X66 3'h6
`define BRMS_PAT_X100 3'h5
`define BRMS_PAT_X133 3'h4

// Short bus-cycle counts
`define BRMS_P_PCI_LOGIC_CYC 14'h0007
`define BRMS_SRST_S_CYC 14'h000b
`define BRMS_SRST_P_CYC 14'h0007
`define BRMS_S_PCI_LOGIC_CYC 14'h0010

// Long bus-cycle counts (defaults of top-level parameters)
`define BRMS_P_LOCK_66_CYC 6678
`define BRMS_P_LOCK_HI_CYC 13350
`define BRMS_XCAP_66_CYC 6675
`define BRMS_XCAP_HI_CYC 13347
`define BRMS_S_LOCK_66_CYC 6687
`define BRMS_S_LOCK_HI_CYC 13359

// Capability sense net charge time
`define BRMS_CLK_PERIOD_NS 8
`define BRMS_CAP_WINDOW_NS 80000

`endif

// [hw/brms_reset_sequencer.v]
// Added by the designer: register access over Avalon-MM and the register offsets.
`include "brms_map.vh"

module brms_reset_sequencer #(
  parameter P_LOCK_66_CYC = `BRMS_P_LOCK_66_CYC,
  parameter P_LOCK_HI_CYC = `BRMS_P_LOCK_HI_CYC,
  parameter XCAP_66_CYC = `BRMS_XCAP_66_CYC,
  parameter XCAP_HI_CYC = `BRMS_XCAP_HI_CYC,
  parameter S_LOCK_66_CYC = `BRMS_S_LOCK_66_CYC,
  parameter S_LOCK_HI_CYC = `BRMS_S_LOCK_HI_CYC,
  parameter CAP_WAIT_CYC = (`BRMS_CAP_WINDOW_NS + `BRMS_CLK_PERIOD_NS - 1) / `BRMS_CLK_PERIOD_NS,
  parameter CNT_W = 14
) (
  // System
  input wire clk_sys_i,
  input wire nrst_i,
  // Avalon-MM slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Upstream bus
  input wire upstream_bus_reset_n_i,
  input wire upstream_clk_i,
  input wire upstream_device_select_n_i,
  input wire upstream_stop_n_i,
  input wire upstream_target_ready_n_i,
  input wire upstream_impedance_invert_i,
  output reg upstream_drive_p2p_o,
  output reg upstream_pll_reset_n_o,
  output reg [1:0] upstream_pll_range_o,
  output reg upstream_logic_reset_n_o,
  // Downstream bus
  input wire downstream_clk_i,
  input wire downstream_clk_good_i,
  input wire downstream_capability_sense_i,
  input wire downstream_freq_range_select_i,
  input wire downstream_impedance_invert_i,
  output wire downstream_bus_reset_n_o,
  output reg capability_strong_pullup_en_o,
  output reg downstream_drive_p2p_o,
  output reg downstream_pll_reset_n_o,
  output reg [1:0] downstream_pll_range_o,
  output reg downstream_logic_reset_n_o,
  output reg [31:0] downstream_ad_o,
  output reg downstream_ad_oe_o,
  output reg [3:0] downstream_cmd_byte_en_o,
  output reg downstream_cmd_byte_en_oe_o,
  output reg downstream_parity_o,
  output reg downstream_parity_oe_o,
  output reg downstream_wide_request_n_o,
  output reg downstream_wide_request_n_oe_o,
  output reg [2:0] downstream_pattern_o,
  output reg downstream_pattern_oe_o
);

  localparam NSYNC = 11;
  localparam IX_PRST = 0;
  localparam IX_PCLK = 1;
  localparam IX_SCLK = 2;
  localparam IX_DEVSEL = 3;
  localparam IX_STOP = 4;
  localparam IX_TRDY = 5;
  localparam IX_PINV = 6;
  localparam IX_SINV = 7;
  localparam IX_CAP = 8;
  localparam IX_SEL = 9;
  localparam IX_GOOD = 10;

  localparam [2:0] P_RST = 3'h1;
  localparam [2:0] P_WAIT = 3'h2;
  localparam [2:0] P_RUN = 3'h4;

  localparam [6:0] S_HOLD = 7'h01;
  localparam [6:0] S_CLKW = 7'h02;
  localparam [6:0] S_XCAP = 7'h04;
  localparam [6:0] S_BCS = 7'h08;
  localparam [6:0] S_BCP = 7'h10;
  localparam [6:0] S_REL = 7'h20;
  localparam [6:0] S_RUN = 7'h40;

  localparam [2:0] D_SAMPLE = 3'h1;
  localparam [2:0] D_PULLUP = 3'h2;
  localparam [2:0] D_DONE = 3'h4;

  localparam [CNT_W-1:0] P_LOCK_66 = P_LOCK_66_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] P_LOCK_HI = P_LOCK_HI_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] XCAP_66 = XCAP_66_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] XCAP_HI = XCAP_HI_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] S_LOCK_66 = S_LOCK_66_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] S_LOCK_HI = S_LOCK_HI_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] CAP_WAIT = CAP_WAIT_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  // Pin synchronisers; stage one feeds stage two only
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  reg pclk_d_r;
  reg sclk_d_r;
  reg prst_d_r;
  wire [NSYNC-1:0] pins;
  wire p_edge;
  wire s_edge;
  wire prst_s;

  assign pins = {downstream_clk_good_i, downstream_freq_range_select_i,
                 downstream_capability_sense_i, downstream_impedance_invert_i,
                 upstream_impedance_invert_i, upstream_target_ready_n_i,
                 upstream_stop_n_i, upstream_device_select_n_i,
                 downstream_clk_i, upstream_clk_i, upstream_bus_reset_n_i};

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
      pclk_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
      prst_d_r <= 1'b0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      pclk_d_r <= sync2_r[IX_PCLK];
      sclk_d_r <= sync2_r[IX_SCLK];
      prst_d_r <= sync2_r[IX_PRST];
    end
  end

  assign p_edge = sync2_r[IX_PCLK] & ~pclk_d_r;
  assign s_edge = sync2_r[IX_SCLK] & ~sclk_d_r;
  assign prst_s = sync2_r[IX_PRST];

  // Control register and Avalon slave, one wait state per access
  reg sbr_r;
  reg ack_r;
  reg sec_rel_r;
  wire req;
  wire src_active;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sbr_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
      if (!prst_s) begin
        sbr_r <= `BRMS_SBR_RESET;
      end else if (avs_write_i && ack_r && avs_address_i == `BRMS_REG_CTRL &&
                   avs_byteenable_i[0]) begin
        sbr_r <= avs_writedata_i[`BRMS_CTRL_SBR_BIT];
      end
    end
  end

  assign downstream_bus_reset_n_o = sec_rel_r & upstream_bus_reset_n_i & ~sbr_r;
  assign src_active = ~prst_s | sbr_r;

  // Upstream sequence
  reg [2:0] pst_r;
  reg [CNT_W-1:0] pcnt_r;
  reg [1:0] pmode_r;
  reg [1:0] pmode_cap;
  reg [CNT_W-1:0] p_target;

  always @* begin
    case ({sync2_r[IX_DEVSEL], sync2_r[IX_STOP], sync2_r[IX_TRDY]})
      `BRMS_PAT_X66: pmode_cap = `BRMS_MODE_X66;
      `BRMS_PAT_X100: pmode_cap = `BRMS_MODE_X100;
      `BRMS_PAT_X133: pmode_cap = `BRMS_MODE_X133;
      default: pmode_cap = `BRMS_MODE_PCI;
    endcase
  end

  always @* begin
    case (pmode_r)
      `BRMS_MODE_PCI: p_target = `BRMS_P_PCI_LOGIC_CYC;
      `BRMS_MODE_X66: p_target = P_LOCK_66;
      default: p_target = P_LOCK_HI;
    endcase
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pst_r <= P_RST;
      pcnt_r <= CNT_ZERO;
      pmode_r <= `BRMS_MODE_PCI;
      upstream_drive_p2p_o <= 1'b0;
      upstream_pll_reset_n_o <= 1'b0;
      upstream_pll_range_o <= `BRMS_MODE_PCI;
      upstream_logic_reset_n_o <= 1'b0;
    end else if (!prst_s) begin
      pst_r <= P_RST;
      pcnt_r <= CNT_ZERO;
      upstream_pll_reset_n_o <= 1'b0;
      upstream_logic_reset_n_o <= 1'b0;
    end else begin
      case (pst_r)
        P_RST: begin
          if (!prst_d_r) begin
            pmode_r <= pmode_cap;
            upstream_pll_range_o <= pmode_cap;
            upstream_pll_reset_n_o <= (pmode_cap != `BRMS_MODE_PCI);
            upstream_drive_p2p_o <= (pmode_cap == `BRMS_MODE_X133) ^ sync2_r[IX_PINV];
            pcnt_r <= CNT_ZERO;
            pst_r <= P_WAIT;
          end
        end
        P_WAIT: begin
          if (p_edge) begin
            pcnt_r <= pcnt_r + CNT_ONE;
            if (pcnt_r + CNT_ONE >= p_target) begin
              upstream_logic_reset_n_o <= 1'b1;
              pst_r <= P_RUN;
            end
          end
        end
        P_RUN: begin
          upstream_logic_reset_n_o <= 1'b1;
        end
        default: pst_r <= P_RST;
      endcase
    end
  end

  // Downstream sequence
  reg [6:0] sst_r;
  reg [2:0] det_r;
  reg [CNT_W-1:0] scnt_r;
  reg [CNT_W-1:0] sicnt_r;
  reg [CNT_W-1:0] capcnt_r;
  reg si_done_r;
  reg [1:0] smode_r;
  reg [CNT_W-1:0] x_target;
  reg [CNT_W-1:0] si_target;
  reg [2:0] spat;

  always @* begin
    if (pmode_r == `BRMS_MODE_PCI || pmode_r == `BRMS_MODE_X66) begin
      x_target = XCAP_66;
    end else begin
      x_target = XCAP_HI;
    end
    case (smode_r)
      `BRMS_MODE_PCI: si_target = `BRMS_S_PCI_LOGIC_CYC;
      `BRMS_MODE_X66: si_target = S_LOCK_66;
      default: si_target = S_LOCK_HI;
    endcase
    case (smode_r)
      `BRMS_MODE_X66: spat = `BRMS_PAT_X66;
      `BRMS_MODE_X100: spat = `BRMS_PAT_X100;
      `BRMS_MODE_X133: spat = `BRMS_PAT_X133;
      default: spat = `BRMS_PAT_PCI;
    endcase
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sst_r <= S_HOLD;
      det_r <= D_SAMPLE;
      scnt_r <= CNT_ZERO;
      sicnt_r <= CNT_ZERO;
      capcnt_r <= CNT_ZERO;
      si_done_r <= 1'b0;
      sec_rel_r <= 1'b0;
      smode_r <= `BRMS_MODE_PCI;
      capability_strong_pullup_en_o <= 1'b0;
      downstream_drive_p2p_o <= 1'b0;
    end else if (src_active) begin
      sst_r <= S_HOLD;
      sec_rel_r <= 1'b0;
      si_done_r <= 1'b0;
      capability_strong_pullup_en_o <= 1'b0;
    end else begin
      if (s_edge && (sst_r & (S_BCS | S_BCP | S_REL)) != 7'h00) begin
        sicnt_r <= sicnt_r + CNT_ONE;
        if (sicnt_r + CNT_ONE >= si_target) begin
          si_done_r <= 1'b1;
        end
      end
      case (sst_r)
        S_HOLD: sst_r <= S_CLKW;
        S_CLKW: begin
          if (sync2_r[IX_GOOD]) begin
            scnt_r <= CNT_ZERO;
            det_r <= D_SAMPLE;
            sst_r <= S_XCAP;
          end
        end
        S_XCAP: begin
          if (p_edge && scnt_r < x_target) begin
            scnt_r <= scnt_r + CNT_ONE;
          end
          case (det_r)
            D_SAMPLE: begin
              if (sync2_r[IX_CAP]) begin
                smode_r <= sync2_r[IX_SEL] ? `BRMS_MODE_X100 : `BRMS_MODE_X133;
                det_r <= D_DONE;
              end else begin
                capability_strong_pullup_en_o <= 1'b1;
                capcnt_r <= CNT_ZERO;
                det_r <= D_PULLUP;
              end
            end
            D_PULLUP: begin
              capcnt_r <= capcnt_r + CNT_ONE;
              if (capcnt_r + CNT_ONE >= CAP_WAIT) begin
                smode_r <= sync2_r[IX_CAP] ? `BRMS_MODE_X66 : `BRMS_MODE_PCI;
                capability_strong_pullup_en_o <= 1'b0;
                det_r <= D_DONE;
              end
            end
            D_DONE: det_r <= D_DONE;
            default: det_r <= D_SAMPLE;
          endcase
          if (det_r == D_DONE && scnt_r >= x_target) begin
            scnt_r <= CNT_ZERO;
            sicnt_r <= CNT_ZERO;
            si_done_r <= 1'b0;
            sst_r <= S_BCS;
          end
        end
        S_BCS: begin
          if (s_edge) begin
            scnt_r <= scnt_r + CNT_ONE;
            if (scnt_r + CNT_ONE >= `BRMS_SRST_S_CYC) begin
              scnt_r <= CNT_ZERO;
              sst_r <= S_BCP;
            end
          end
        end
        S_BCP: begin
          if (p_edge) begin
            scnt_r <= scnt_r + CNT_ONE;
            if (scnt_r + CNT_ONE >= `BRMS_SRST_P_CYC) begin
              sec_rel_r <= 1'b1;
              downstream_drive_p2p_o <= (smode_r == `BRMS_MODE_X133) ^ sync2_r[IX_SINV];
              sst_r <= S_REL;
            end
          end
        end
        S_REL: begin
          if (si_done_r) begin
            sst_r <= S_RUN;
          end
        end
        S_RUN: sst_r <= S_RUN;
        default: sst_r <= S_HOLD;
      endcase
    end
  end

  // Downstream pin drivers, registered
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      downstream_ad_o <= 32'h0000_0000;
      downstream_ad_oe_o <= 1'b0;
      downstream_cmd_byte_en_o <= 4'h0;
      downstream_cmd_byte_en_oe_o <= 1'b0;
      downstream_parity_o <= 1'b0;
      downstream_parity_oe_o <= 1'b0;
      downstream_wide_request_n_o <= 1'b1;
      downstream_wide_request_n_oe_o <= 1'b0;
      downstream_pattern_o <= `BRMS_PAT_PCI;
      downstream_pattern_oe_o <= 1'b0;
      downstream_pll_reset_n_o <= 1'b0;
      downstream_pll_range_o <= `BRMS_MODE_PCI;
      downstream_logic_reset_n_o <= 1'b0;
    end else begin
      downstream_ad_o <= 32'h0000_0000;
      downstream_cmd_byte_en_o <= 4'h0;
      downstream_parity_o <= 1'b0;
      downstream_ad_oe_o <= ~sec_rel_r;
      downstream_cmd_byte_en_oe_o <= ~sec_rel_r;
      downstream_parity_oe_o <= ~sec_rel_r;
      downstream_wide_request_n_o <= 1'b0;
      downstream_wide_request_n_oe_o <= (sst_r & (S_BCS | S_BCP)) != 7'h00 && !src_active;
      downstream_pattern_o <= spat;
      downstream_pattern_oe_o <= (sst_r & (S_BCS | S_BCP)) != 7'h00 && !src_active;
      downstream_pll_range_o <= smode_r;
      downstream_pll_reset_n_o <= (smode_r != `BRMS_MODE_PCI) && !src_active &&
                                  (sst_r & (S_BCS | S_BCP | S_REL | S_RUN)) != 7'h00;
      downstream_logic_reset_n_o <= (sst_r == S_RUN) && !src_active;
    end
  end

  // Register read data, valid at the edge that ends the wait
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= `BRMS_RDATA_ZERO;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= `BRMS_RDATA_ZERO;
      if (avs_address_i == `BRMS_REG_CTRL) begin
        avs_readdata_o[`BRMS_CTRL_SBR_BIT] <= sbr_r;
      end else if (avs_address_i == `BRMS_REG_STATUS) begin
        avs_readdata_o[`BRMS_ST_PMODE_LO +: 2] <= pmode_r;
        avs_readdata_o[`BRMS_ST_SMODE_LO +: 2] <= smode_r;
        avs_readdata_o[`BRMS_ST_PIMP_BIT] <= upstream_drive_p2p_o;
        avs_readdata_o[`BRMS_ST_SIMP_BIT] <= downstream_drive_p2p_o;
        avs_readdata_o[`BRMS_ST_PLOGIC_BIT] <= upstream_logic_reset_n_o;
        avs_readdata_o[`BRMS_ST_SLOGIC_BIT] <= downstream_logic_reset_n_o;
        avs_readdata_o[`BRMS_ST_SBUS_BIT] <= sec_rel_r;
        avs_readdata_o[`BRMS_ST_CLKGOOD_BIT] <= sync2_r[IX_GOOD];
      end
    end
  end

endmodule // brms_reset_sequencer
